/* csf_map.svh */
// Offsets, field positions and counts for the core status flags unit.
// Assumes inclusion by its bare name; definitions only.
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH
`define CSF_FLAG_CARRY 3
`define CSF_FLAG_CARRY_BIT 0
`define CSF_FLAG_HALF_BIT 1
`define CSF_FLAG_ZERO_BIT 2
`define CSF_FLAG_OVF_BIT 3
`define CSF_FLAG_HALT_BIT 4
`define CSF_FLAG_WDT_BIT 5
`define CSF_FLAGS_RESET 8'h00
`define CSF_ACC_RESET 8'h00
`define CSF_PCL_RESET 8'h00
`define CSF_SW_WRITE_MASK 8'h0f
`define CSF_DUMMY_CYCLES 1
`endif

/* csf_pkg.sv */
// Types for the core status flags unit.
// Assumes csf_map.svh supplies the numeric constants.
package csf_pkg;
    typedef enum logic [3:0] {
        CSF_OP_NOP = 4'h0,
        CSF_OP_ADD = 4'h1,
        CSF_OP_ADC = 4'h2,
        CSF_OP_SUB = 4'h3,
        CSF_OP_SBC = 4'h4,
        CSF_OP_AND = 4'h5,
        CSF_OP_OR = 4'h6,
        CSF_OP_XOR = 4'h7,
        CSF_OP_RLC = 4'h8,
        CSF_OP_RRC = 4'h9,
        CSF_OP_MOV = 4'ha
    } csf_op_t;

    typedef struct packed {
        logic [7:0] res;
        logic carry;
        logic half;
        logic zero;
        logic ovf;
        logic arith;
        logic logic_op;
    } csf_alu_out_t;

    typedef struct packed {
        logic valid;
        csf_op_t op;
        logic [7:0] operand;
    } csf_alu_req_t;
endpackage

/* csf_alu.sv */
// Combinational ALU that computes result and flag candidates.
// Assumes operands and carry-in come from the same clock domain.
`timescale 1ns/10ps
module csf_alu (
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire csf_pkg::csf_op_t op,
    input wire logic cin,
    output csf_pkg::csf_alu_out_t out
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    logic c_in_eff;
    logic c_into_msb;

    // Arithmetic, logic and rotate results with flag candidates
    always_comb begin
        addend = opnd;
        c_in_eff = 1'b0;
        out = '0;
        unique case (op)
            csf_pkg::CSF_OP_ADC: c_in_eff = cin;
            csf_pkg::CSF_OP_SUB: begin
                addend = ~opnd;
                c_in_eff = 1'b1;
            end
            csf_pkg::CSF_OP_SBC: begin
                addend = ~opnd;
                c_in_eff = cin;
            end
            default: c_in_eff = 1'b0;
        endcase
        sum = {1'b0, acc} + {1'b0, addend} + {8'h00, c_in_eff};
        low = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, c_in_eff};
        c_into_msb = acc[7] ^ addend[7] ^ sum[7];
        unique case (op)
            csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC,
            csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
                out.res = sum[7:0];
                out.carry = sum[8]; // Carry out, or no borrow
                out.half = low[4];
                out.ovf = c_into_msb ^ sum[8];
                out.arith = 1'b1;
            end
            csf_pkg::CSF_OP_AND: out.res = acc & opnd;
            csf_pkg::CSF_OP_OR: out.res = acc | opnd;
            csf_pkg::CSF_OP_XOR: out.res = acc ^ opnd;
            csf_pkg::CSF_OP_RLC: begin
                out.res = {opnd[6:0], cin};
                out.carry = opnd[7];
            end
            csf_pkg::CSF_OP_RRC: begin
                out.res = {cin, opnd[7:1]};
                out.carry = opnd[0];
            end
            default: out.res = opnd;
        endcase
        out.logic_op = (op == csf_pkg::CSF_OP_AND) || (op == csf_pkg::CSF_OP_OR)
            || (op == csf_pkg::CSF_OP_XOR);
        out.zero = (out.res == 8'h00);
    end
endmodule

/* csf_core_status_flags_unit.sv */
// Accumulator, status flags and in-page jump of an 8-bit core.
// Assumes the instruction decoder drives all requests on clk_sys.
`timescale 1ns/10ps
`include "csf_map.svh"
module csf_core_status_flags_unit #(
    parameter int PC_WIDTH = 12
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire csf_pkg::csf_alu_req_t alu_req,
    input wire logic flags_wr,
    input wire logic [7:0] flags_wr_data,
    input wire logic pcl_wr,
    input wire logic [7:0] pcl_wr_data,
    input wire logic pc_advance,
    input wire logic watchdog_refresh_instruction,
    input wire logic sleep_instruction,
    input wire logic watchdog_timeout,
    output logic [7:0] working_accumulator,
    output logic [7:0] arith_flags_register,
    output logic [PC_WIDTH-1:0] program_counter,
    output logic [7:0] program_counter_low_byte,
    output logic dummy_cycle
);
    csf_pkg::csf_alu_out_t alu_out;
    logic [7:0] acc_q, acc_d;
    logic [7:0] flags_q, flags_d;
    logic [PC_WIDTH-1:0] pc_q, pc_d;
    logic dummy_q, dummy_d;
    logic alu_go;

    assign alu_go = alu_req.valid && (alu_req.op != csf_pkg::CSF_OP_NOP);

    csf_alu u_alu (
        .acc(acc_q),
        .opnd(alu_req.operand),
        .op(alu_req.op),
        .cin(flags_q[`CSF_FLAG_CARRY_BIT]),
        .out(alu_out)
    );

    // Accumulator receives every ALU result except NOP, including moves
    always_comb begin
        acc_d = acc_q;
        if (alu_go) begin
            acc_d = alu_out.res;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc_q <= `CSF_ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Status flags: software write, then ALU update, then system events
    always_comb begin
        flags_d = flags_q;
        if (flags_wr) begin
            // Only carry, half, zero, overflow take written data
            flags_d = (flags_q & ~`CSF_SW_WRITE_MASK)
                | (flags_wr_data & `CSF_SW_WRITE_MASK);
        end
        if (alu_go) begin
            if (alu_out.arith) begin
                flags_d[`CSF_FLAG_CARRY_BIT] = alu_out.carry;
                flags_d[`CSF_FLAG_HALF_BIT] = alu_out.half;
                flags_d[`CSF_FLAG_OVF_BIT] = alu_out.ovf;
            end
            if (alu_req.op == csf_pkg::CSF_OP_RLC || alu_req.op == csf_pkg::CSF_OP_RRC) begin
                flags_d[`CSF_FLAG_CARRY_BIT] = alu_out.carry;
            end
            if (alu_out.arith || alu_out.logic_op) begin
                flags_d[`CSF_FLAG_ZERO_BIT] = alu_out.zero;
            end
        end
        if (watchdog_refresh_instruction) begin
            flags_d[`CSF_FLAG_HALT_BIT] = 1'b0;
            flags_d[`CSF_FLAG_WDT_BIT] = 1'b0;
        end
        if (sleep_instruction) begin
            flags_d[`CSF_FLAG_HALT_BIT] = 1'b1;
            flags_d[`CSF_FLAG_WDT_BIT] = 1'b0;
        end
        if (watchdog_timeout) begin
            flags_d[`CSF_FLAG_WDT_BIT] = 1'b1; // Set wins
        end
        flags_d[7:6] = 2'b00;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_q <= `CSF_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Program counter: low byte load stays in page and stalls once
    always_comb begin
        pc_d = pc_q;
        dummy_d = 1'b0;
        if (pcl_wr) begin
            pc_d = {pc_q[PC_WIDTH-1:8], pcl_wr_data};
            dummy_d = 1'b1;
        end else if (pc_advance && !dummy_q) begin
            pc_d = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc_q <= '0;
            dummy_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            dummy_q <= dummy_d;
        end
    end

    // Outputs straight from flip-flops
    assign working_accumulator = acc_q;
    assign arith_flags_register = flags_q;
    assign program_counter = pc_q;
    assign program_counter_low_byte = pc_q[7:0];
    assign dummy_cycle = dummy_q;

    // Checks on the flag, accumulator and jump behaviour
    chk_wr_keeps_sys: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (flags_wr && !watchdog_refresh_instruction && !sleep_instruction && !watchdog_timeout)
        |=> flags_q[5:4] == $past(flags_q[5:4]))
        else $error("Status write changed halt or watchdog flag");
    chk_wr_sets_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (flags_wr && !alu_go) |=> flags_q[3:0] == $past(flags_wr_data[3:0]))
        else $error("Status write did not land");
    chk_sleep_sets_halt: assert property (@(posedge clk_sys) disable iff (sys_rst)
        sleep_instruction |=> flags_q[`CSF_FLAG_HALT_BIT])
        else $error("Sleep did not set halt flag");
    chk_halt_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sleep_instruction && !watchdog_refresh_instruction)
        |=> $stable(flags_q[`CSF_FLAG_HALT_BIT]))
        else $error("Halt flag changed without cause");
    chk_wdt_timeout: assert property (@(posedge clk_sys) disable iff (sys_rst)
        watchdog_timeout |=> flags_q[`CSF_FLAG_WDT_BIT])
        else $error("Timeout did not set watchdog flag");
    chk_wdt_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!sleep_instruction && !watchdog_refresh_instruction && !watchdog_timeout)
        |=> $stable(flags_q[`CSF_FLAG_WDT_BIT]))
        else $error("Watchdog flag changed without cause");
    chk_zero_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && (alu_out.arith || alu_out.logic_op))
        |=> flags_q[`CSF_FLAG_ZERO_BIT] == (acc_q == 8'h00))
        else $error("Zero flag disagrees with result");
    chk_add_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_ADD)
        |=> flags_q[0] == ({1'b0, $past(acc_q)} + {1'b0, $past(alu_req.operand)} > 9'h0ff))
        else $error("Add carry wrong");
    chk_acc_takes: assert property (@(posedge clk_sys) disable iff (sys_rst)
        alu_go |=> acc_q == $past(alu_out.res))
        else $error("Accumulator missed ALU result");
    chk_pcl_jump: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pcl_wr |=> dummy_q && pc_q[7:0] == $past(pcl_wr_data)
            && pc_q[PC_WIDTH-1:8] == $past(pc_q[PC_WIDTH-1:8]))
        else $error("Low byte jump left page or no dummy cycle");
    chk_high_bits_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        flags_q[7:6] == 2'b00)
        else $error("Reserved status bits not zero");

    // Flag and accumulator values worked out from the operands, apart from the ALU
    chk_sub_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_SUB)
        |=> flags_q[`CSF_FLAG_CARRY_BIT] == ($past(acc_q) >= $past(alu_req.operand)))
        else $error("Subtract carry wrong");
    chk_half_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_ADD)
        |=> flags_q[`CSF_FLAG_HALF_BIT]
            == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(alu_req.operand[3:0])}) > 5'h0f))
        else $error("Add half carry wrong");
    chk_ovf_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_ADD)
        |=> flags_q[`CSF_FLAG_OVF_BIT] == (($past(acc_q[7]) == $past(alu_req.operand[7]))
            && (acc_q[7] != $past(acc_q[7]))))
        else $error("Add overflow wrong");
    chk_rlc_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_RLC)
        |=> flags_q[`CSF_FLAG_CARRY_BIT] == $past(alu_req.operand[7])
            && acc_q[0] == $past(flags_q[`CSF_FLAG_CARRY_BIT]))
        else $error("Rotate did not pass through carry");
    chk_mov_passes: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_MOV) |=> acc_q == $past(alu_req.operand))
        else $error("Move did not reach accumulator");
    chk_and_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (alu_go && alu_req.op == csf_pkg::CSF_OP_AND)
        |=> acc_q == ($past(acc_q) & $past(alu_req.operand)))
        else $error("Logic result missed accumulator");

    // Jump stall and system flag clears
    chk_dummy_stall: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (dummy_q && !pcl_wr)
        |=> $stable(pc_q))
        else $error("Program counter moved in dummy cycle");
    chk_sleep_clears_wdt: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (sleep_instruction && !watchdog_timeout) |=> !flags_q[`CSF_FLAG_WDT_BIT])
        else $error("Sleep did not clear watchdog flag");
    chk_refresh_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (watchdog_refresh_instruction && !sleep_instruction)
        |=> !flags_q[`CSF_FLAG_HALT_BIT])
        else $error("Refresh did not clear halt flag");
endmodule

/* csf_testbench.sv */
// Self-checking bench for the core status flags unit, with a reference model.
// Assumes registered outputs follow a request by one clock and reset is synchronous.
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    csf_pkg::csf_alu_req_t alu_req = '0;
    logic flags_wr = 1'b0;
    logic [7:0] flags_wr_data = 8'h00;
    logic pcl_wr = 1'b0;
    logic [7:0] pcl_wr_data = 8'h00;
    logic pc_advance = 1'b0;
    logic watchdog_refresh_instruction = 1'b0;
    logic sleep_instruction = 1'b0;
    logic watchdog_timeout = 1'b0;
    logic [7:0] working_accumulator;
    logic [7:0] arith_flags_register;
    logic [11:0] program_counter;
    logic [7:0] program_counter_low_byte;
    logic dummy_cycle;
    int n_errors = 0;
    int comparisons = 0;
    int m_acc = 0;
    logic [7:0] m_fl = 8'h00;
    logic [11:0] m_pc = 12'h000;
    logic m_dm = 1'b0;
    logic [15:0] lfsr = 16'h3c24;

    // Unit under test
    csf_core_status_flags_unit #(.PC_WIDTH(12)) dut_u (
        .clk_sys, .sys_rst, .alu_req, .flags_wr, .flags_wr_data, .pcl_wr, .pcl_wr_data,
        .pc_advance, .watchdog_refresh_instruction, .sleep_instruction, .watchdog_timeout,
        .working_accumulator, .arith_flags_register, .program_counter,
        .program_counter_low_byte, .dummy_cycle
    );

    // Free-running core clock, 8 ns period
    always #4 clk_sys = ~clk_sys;

    // Pseudo-random source for stimulus
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // Compare one observed value against the model
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Summary and verdict
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Drive one cycle of random requests and advance the model
    task automatic step(input int i);
        logic [15:0] r1, r2, r3;
        int a, b, ci, s, lo, s7, op, o;
        logic c0;
        r1 = rnd();
        r2 = rnd();
        r3 = rnd();
        op = r1[15:8] % 11;
        o = r2[7:0];
        sys_rst = (i < 10) || (i == 1500);
        alu_req.valid = r1[0] | r1[1];
        alu_req.op = csf_pkg::csf_op_t'(4'(op));
        alu_req.operand = r2[7:0];
        flags_wr = r1[2] & r1[3];
        flags_wr_data = r2[15:8];
        pcl_wr = (r3[2:0] == 3'h0) && !m_dm;
        pcl_wr_data = r3[15:8];
        pc_advance = r3[3];
        watchdog_refresh_instruction = &r3[6:4];
        sleep_instruction = &r3[7:5];
        watchdog_timeout = r3[4] & r3[7] & r1[4];
        if (sys_rst) begin
            m_acc = 0;
            m_fl = 8'h00;
            m_pc = 12'h000;
            m_dm = 1'b0;
        end else begin
            if (pcl_wr) m_pc[7:0] = pcl_wr_data;
            else if (pc_advance && !m_dm) m_pc = m_pc + 12'h001;
            m_dm = pcl_wr;
            c0 = m_fl[0];
            a = m_acc;
            if (flags_wr) m_fl[3:0] = flags_wr_data[3:0];
            if (alu_req.valid) begin
                if (op >= 1 && op <= 4) begin
                    b = (op >= 3) ? (o ^ 255) : o;
                    ci = (op == 1) ? 0 : (op == 3) ? 1 : int'(c0);
                    s = a + b + ci;
                    lo = (a % 16) + (b % 16) + ci;
                    s7 = (a % 128) + (b % 128) + ci;
                    m_acc = s % 256;
                    // Ovf, zero, half, carry
                    m_fl[3:0] = {1'((s7 / 128) ^ (s / 256)), m_acc == 0, 1'(lo / 16), 1'(s / 256)};
                end else if (op >= 5 && op <= 7) begin
                    m_acc = (op == 5) ? (a & o) : (op == 6) ? (a | o) : (a ^ o);
                    m_fl[2] = (m_acc == 0);
                end else if (op == 8) begin
                    m_acc = (o * 2) % 256 + int'(c0);
                    m_fl[0] = 1'(o / 128);
                end else if (op == 9) begin
                    m_acc = o / 2 + int'(c0) * 128;
                    m_fl[0] = 1'(o % 2);
                end else if (op == 10) m_acc = o;
            end
            if (watchdog_refresh_instruction) m_fl[5:4] = 2'b00;
            if (sleep_instruction) m_fl[5:4] = 2'b01;
            if (watchdog_timeout) m_fl[5] = 1'b1;
        end
    endtask

    // Main sequence: compare at each falling edge after the first, then drive the next cycle
    initial begin
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk_sys);
            if (i > 0) begin
                check("accumulator", 16'(working_accumulator), 16'(m_acc));
                check("arith flags", 16'(arith_flags_register[3:0]), 16'(m_fl[3:0]));
                check("system flags", 16'(arith_flags_register[5:4]), 16'(m_fl[5:4]));
                check("spare flags", 16'(arith_flags_register[7:6]), 16'h0000);
                check("program counter", 16'(program_counter), 16'(m_pc));
                check("pc low byte", 16'(program_counter_low_byte), 16'(m_pc[7:0]));
                check("dummy cycle", 16'(dummy_cycle), 16'(m_dm));
            end
            step(i);
        end
        complete_run();
    end
endmodule
